// [tos_pkg.sv]
package tos_pkg;

  // ------------------------------------------------------------
  // source selection codes
  // ------------------------------------------------------------
  localparam int SEL_W = 4;
  localparam logic [SEL_W-1:0] SRC_HSYNC = 4'h0;
  localparam logic [SEL_W-1:0] SRC_HBLANK = 4'h1;
  localparam logic [SEL_W-1:0] SRC_VSYNC = 4'h2;
  localparam logic [SEL_W-1:0] SRC_VBLANK = 4'h3;
  localparam logic [SEL_W-1:0] SRC_FSYNC = 4'h4;
  localparam logic [SEL_W-1:0] SRC_FDIGITAL = 4'h5;
  localparam logic [SEL_W-1:0] SRC_DISPEN = 4'h6;
  localparam logic [SEL_W-1:0] SRC_CADENCE = 4'h7;
  localparam logic [SEL_W-1:0] SRC_AVFSYNC = 4'h8;
  localparam logic [SEL_W-1:0] SRC_USER1 = 4'h9;
  localparam logic [SEL_W-1:0] SRC_USER2 = 4'hA;
  localparam logic [SEL_W-1:0] SRC_USER3 = 4'hB;
  localparam logic [SEL_W-1:0] SRC_USER4 = 4'hC;
  localparam int NUM_SRC = 13;

  // ------------------------------------------------------------
  // outputs, standard field, register map
  // ------------------------------------------------------------
  localparam int NUM_OUT = 4;
  localparam int STD_W = 6;
  localparam logic [STD_W-1:0] STD_NONE = 6'h00;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // one select register per output at SEL_BASE + index
  localparam logic [ADDR_W-1:0] SEL_BASE = 4'h0;
  localparam logic [ADDR_W-1:0] DRIVE_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] STD_ADDR = 4'h5;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h6;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [NUM_OUT-1:0] DRIVE_RST = 4'h0;
  localparam logic [STD_W-1:0] STD_RST = 6'h00;
  localparam logic [NUM_OUT*SEL_W-1:0] SEL_RST =
    {SRC_FSYNC, SRC_VBLANK, SRC_VSYNC, SRC_HBLANK};

endpackage

// [tos_out_cell.sv]
// one timing output: source mux, registered level and enable
module tos_out_cell (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [tos_pkg::NUM_SRC-1:0] srcBus,
  input wire logic [tos_pkg::SEL_W-1:0] srcSel,
  input wire logic outEnable,
  output logic pinOut,
  output logic pinOe
);

  // ------------------------------------------------------------
  // selection
  // ------------------------------------------------------------
  // codes beyond the last source select a quiet low level
  logic selValid;
  logic selLevel;
  assign selValid = 32'(srcSel) < tos_pkg::NUM_SRC;
  assign selLevel = selValid ? srcBus[srcSel] : 1'b0;

  // registered, so a reselection cannot glitch the pin
  logic pinOut_reg;
  logic pinOe_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut_reg <= 1'b0;
      pinOe_reg <= 1'b0;
    end else if (clkEn) begin
      pinOut_reg <= selLevel;
      pinOe_reg <= outEnable;
    end
  end
  assign pinOut = pinOut_reg;
  assign pinOe = pinOe_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sel_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn |=> pinOut == $past(selLevel))
    else $error("pin level does not follow selected source");
  sel_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && selValid |=> pinOut == $past(srcBus[srcSel]))
    else $error("pin not routed from chosen source");
  freeze_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clkEn |=> $stable(pinOut) && $stable(pinOe))
    else $error("cell changed while clock enable low");

endmodule

// [tos_timing_out.sv]
// ------------------------------------------------------------
// Contract
// - Each output can be routed from any one of the thirteen sources.
// - Output two carries horizontal blanking after reset.
// - Output three carries vertical sync after reset.
// - Output four carries vertical blanking after reset.
// - Output five carries field sync after reset.
// - All outputs float while the video standard field is zero.
// - Each output has a high/low drive setting that resets to low.
// ------------------------------------------------------------
//
// Decided for this implementation: the register offsets and the strobed register port.
module tos_timing_out (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [tos_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tos_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [tos_pkg::DATA_W-1:0] regRdata,
  input wire logic hSync,
  input wire logic hBlank,
  input wire logic vSync,
  input wire logic vBlank,
  input wire logic fieldSync,
  input wire logic fieldDigital,
  input wire logic displayEnable,
  input wire logic cadenceId,
  input wire logic audioVideoFrameSync,
  input wire logic [3:0] userTiming,
  output logic [tos_pkg::NUM_OUT-1:0] timingOut,
  output logic [tos_pkg::NUM_OUT-1:0] timingOe,
  output logic [tos_pkg::NUM_OUT-1:0] driveHigh
);

  // ------------------------------------------------------------
  // source bus, ordered by selection code
  // ------------------------------------------------------------
  logic [tos_pkg::NUM_SRC-1:0] srcBus;
  assign srcBus = {userTiming, audioVideoFrameSync, cadenceId,
                   displayEnable, fieldDigital, fieldSync, vBlank,
                   vSync, hBlank, hSync};

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  localparam int SW = tos_pkg::SEL_W;
  localparam int SELS_W = tos_pkg::NUM_OUT * SW;
  logic [SELS_W-1:0] sel_reg;
  logic [SELS_W-1:0] sel_next;
  logic [tos_pkg::NUM_OUT-1:0] drive_reg;
  logic [tos_pkg::NUM_OUT-1:0] drive_next;
  logic [tos_pkg::STD_W-1:0] std_reg;
  logic [tos_pkg::STD_W-1:0] std_next;
  logic [tos_pkg::DATA_W-1:0] rdata_reg;
  logic [tos_pkg::DATA_W-1:0] rdata_next;
  logic [tos_pkg::NUM_OUT-1:0] selHit;
  logic driveHit;
  logic stdHit;
  logic outEnable;

  assign driveHit = regWr && regAddr == tos_pkg::DRIVE_ADDR;
  assign stdHit = regWr && regAddr == tos_pkg::STD_ADDR;
  assign drive_next = driveHit ? regWdata[tos_pkg::NUM_OUT-1:0]
                               : drive_reg;
  assign std_next = stdHit ? regWdata[tos_pkg::STD_W-1:0] : std_reg;
  // no standard chosen means every pin floats
  assign outEnable = std_reg != tos_pkg::STD_NONE;

  // per-output select registers and output cells
  genvar g;
  generate
    for (g = 0; g < tos_pkg::NUM_OUT; g++) begin : gOut
      assign selHit[g] = regWr &&
        regAddr == tos_pkg::SEL_BASE + tos_pkg::ADDR_W'(g);
      assign sel_next[g*SW +: SW] = selHit[g] ?
        regWdata[SW-1:0] : sel_reg[g*SW +: SW];
      tos_out_cell uCell (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .srcBus(srcBus),
        .srcSel(sel_reg[g*SW +: SW]),
        .outEnable(outEnable),
        .pinOut(timingOut[g]),
        .pinOe(timingOe[g])
      );
    end
  endgenerate

  // read mux; unmapped addresses read zero
  logic [tos_pkg::DATA_W-1:0] rdMux;
  logic [tos_pkg::ADDR_W-1:0] rdIdx;
  assign rdIdx = regAddr - tos_pkg::SEL_BASE;
  assign rdMux =
    (regAddr < tos_pkg::DRIVE_ADDR) ?
      tos_pkg::DATA_W'(sel_reg[rdIdx[1:0]*SW +: SW]) :
    (regAddr == tos_pkg::DRIVE_ADDR) ? tos_pkg::DATA_W'(drive_reg) :
    (regAddr == tos_pkg::STD_ADDR) ? tos_pkg::DATA_W'(std_reg) :
    (regAddr == tos_pkg::STATUS_ADDR) ?
      tos_pkg::DATA_W'({timingOe, timingOut}) :
    tos_pkg::READ_ZERO;
  assign rdata_next = regRd ? rdMux : tos_pkg::READ_ZERO;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // reset defaults give each pin its usual timing signal
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= tos_pkg::SEL_RST;
      drive_reg <= tos_pkg::DRIVE_RST;
      std_reg <= tos_pkg::STD_RST;
      rdata_reg <= tos_pkg::READ_ZERO;
    end else if (clkEn) begin
      sel_reg <= sel_next;
      drive_reg <= drive_next;
      std_reg <= std_next;
      rdata_reg <= rdata_next;
    end
  end
  assign regRdata = rdata_reg;
  assign driveHigh = drive_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence sel_write_s(int i);
    clkEn && regWr && regAddr == tos_pkg::SEL_BASE + tos_pkg::ADDR_W'(i);
  endsequence

  float_none_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && std_reg == tos_pkg::STD_NONE |=> timingOe == '0)
    else $error("outputs driven with no standard chosen");
  drive_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && std_reg != tos_pkg::STD_NONE |=> timingOe == '1)
    else $error("outputs floating with a standard chosen");
  drive_low_a: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> driveHigh == tos_pkg::DRIVE_RST)
    else $error("drive setting not low after reset");
  drive_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && driveHit |=> driveHigh == $past(regWdata[3:0]))
    else $error("drive setting not taken from write");
  dflt_two_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) && !regWr |=> sel_reg[SW-1:0] == tos_pkg::SRC_HBLANK)
    else $error("output two default wrong");
  dflt_three_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) && !regWr |=> sel_reg[2*SW-1:SW] == tos_pkg::SRC_VSYNC)
    else $error("output three default wrong");
  dflt_four_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) && !regWr |=>
      sel_reg[3*SW-1:2*SW] == tos_pkg::SRC_VBLANK)
    else $error("output four default wrong");
  dflt_five_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) && !regWr |=>
      sel_reg[4*SW-1:3*SW] == tos_pkg::SRC_FSYNC)
    else $error("output five default wrong");
  // the cell's follow check carries the new code on to the pin
  sel_apply_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sel_write_s(0) |=>
      sel_reg[SW-1:0] == $past(regWdata[SW-1:0]))
    else $error("new selection not taken at the write edge");
  rd_timing_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && regRd && regAddr == tos_pkg::STD_ADDR |=>
      regRdata == tos_pkg::DATA_W'(std_reg))
    else $error("standard read back wrong");

endmodule

// [tos_video_sink.sv]
// downstream video logic that sees the four timing pins
module tos_video_sink (
  input wire logic sys_clk,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  output logic [3:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lastReg = 4'h0;
  // a released pin has no pull, so it shows a level that flips each cycle
  always_ff @(posedge sys_clk) lastReg <= pinLevel;
  // wire level worked out from the design's enable
  assign pinLevel = (pinOe & pinOut) | (~pinOe & ~lastReg);
endmodule

// [testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, enRand = 1'b0;
  logic regWr = 1'b0, regRd = 1'b0;
  logic [3:0] regAddr = 4'h0, timingOut, timingOe, driveHigh, pinLevel;
  logic [3:0] drvM, expOe, expTo, d;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [12:0] srcV = 13'h0000;
  logic [15:0] selM;
  logic [5:0] stdM;
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  always #25 sys_clk = ~sys_clk;
  tos_timing_out DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .hSync(srcV[0]), .hBlank(srcV[1]),
    .vSync(srcV[2]), .vBlank(srcV[3]), .fieldSync(srcV[4]),
    .fieldDigital(srcV[5]), .displayEnable(srcV[6]), .cadenceId(srcV[7]),
    .audioVideoFrameSync(srcV[8]), .userTiming(srcV[12:9]),
    .timingOut(timingOut), .timingOe(timingOe), .driveHigh(driveHigh));
  tos_video_sink sink (.sys_clk(sys_clk), .pinOut(timingOut),
    .pinOe(timingOe), .pinLevel(pinLevel));
  // ------------------------------------------------------------
  // expectation model
  // ------------------------------------------------------------
  function automatic logic srcOf(logic [12:0] v, logic [3:0] s);
    return (s < 4'hD) ? v[s] : 1'b0;
  endfunction
  // register copy and output pipeline, frozen with the clock enable
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      selM <= tos_pkg::SEL_RST;
      {drvM, expOe, expTo} <= 12'h000;
      stdM <= 6'h00;
    end else if (clkEn) begin
      if (regWr && regAddr < 4'h4) selM[regAddr*4 +: 4] <= regWdata[3:0];
      if (regWr && regAddr == tos_pkg::DRIVE_ADDR) drvM <= regWdata[3:0];
      if (regWr && regAddr == tos_pkg::STD_ADDR) stdM <= regWdata[5:0];
      for (int i = 0; i < 4; i++) expTo[i] <= srcOf(srcV, selM[i*4 +: 4]);
      // register holds new field after the write edge, pin one edge later
      expOe <= {4{stdM != 6'h00}};
    end
  end
  task automatic check(logic [7:0] got, logic [7:0] exp, string msg);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // pins compared every cycle; released bits are masked off
  always @(negedge sys_clk) if (rst_n) begin
    check({4'h0, timingOe}, {4'h0, expOe}, "enable");
    check({4'h0, pinLevel & expOe}, {4'h0, expTo & expOe}, "pin");
    check({4'h0, driveHigh}, {4'h0, drvM}, "drive model");
  end
  // sources change every cycle; the enable drops now and then
  always @(posedge sys_clk) begin
    srcV <= 13'($urandom);
    clkEn <= enRand ? ($urandom % 8 != 0) : 1'b1;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // register bus tasks and verdict
  // ------------------------------------------------------------
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] exp, string msg);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    check(regRdata, exp, msg);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h0000_1e93));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd(4'(i), {4'h0, tos_pkg::SEL_RST[i*4 +: 4]}, "sel");
    rd(tos_pkg::DRIVE_ADDR, 8'h00, "drive reset");
    rd(tos_pkg::STD_ADDR, 8'h00, "std reset");
    $display("test reset values done");
    wr(tos_pkg::STD_ADDR, {2'b00, 6'(1 + $urandom % 63)});
    repeat (20) @(posedge sys_clk);
    $display("test default routing done");
    for (int c = 0; c < 16; c++)
      for (int i = 0; i < 4; i++) begin
        wr(4'(i), 8'(c));
        repeat (3) @(posedge sys_clk);
      end
    rd(4'h3, 8'h0F, "sel readback");
    $display("test every source done");
    repeat (4) begin
      d = 4'($urandom);
      wr(tos_pkg::DRIVE_ADDR, {4'h0, d});
      repeat (2) @(posedge sys_clk);
      check({4'h0, driveHigh}, {4'h0, d}, "drive pin");
      rd(tos_pkg::DRIVE_ADDR, {4'h0, d}, "drive reg");
    end
    $display("test drive done");
    enRand <= 1'b1;
    repeat (60) wr(4'($urandom % 4), 8'($urandom % 13));
    wr(4'h7 + 4'($urandom % 9), 8'($urandom));
    enRand <= 1'b0;
    for (int a = 7; a < 16; a++) rd(4'(a), 8'h00, "unmapped");
    $display("test random selection done");
    wr(tos_pkg::STD_ADDR, 8'h00);
    repeat (6) @(posedge sys_clk);
    $display("test float done");
    summarize();
  end
endmodule
